// *** core/aifq_defs.vh ***
// Purpose: shared constants of the interrupt, format and sample queue back end
// Assumes: byte-wide register port, 13-bit raw samples at 4 mg per step
// Notes: definitions only
`ifndef AIFQ_DEFS_VH
`define AIFQ_DEFS_VH

// register offsets
`define AIFQ_OFS_INT_ENABLE 8'h2E
`define AIFQ_OFS_PIN_SELECT 8'h2F
`define AIFQ_OFS_EVT_FLAGS 8'h30
`define AIFQ_OFS_FORMAT 8'h31
`define AIFQ_OFS_X_LOW 8'h32
`define AIFQ_OFS_X_HIGH 8'h33
`define AIFQ_OFS_Y_LOW 8'h34
`define AIFQ_OFS_Y_HIGH 8'h35
`define AIFQ_OFS_Z_LOW 8'h36
`define AIFQ_OFS_Z_HIGH 8'h37
`define AIFQ_OFS_QUEUE_CTRL 8'h38
`define AIFQ_OFS_QUEUE_STATUS 8'h39

// reset values
`define AIFQ_RST_BYTE 8'h00

// event flag positions
`define AIFQ_EVT_DREADY 7
`define AIFQ_EVT_STAP 6
`define AIFQ_EVT_DTAP 5
`define AIFQ_EVT_ACT 4
`define AIFQ_EVT_INACT 3
`define AIFQ_EVT_FFALL 2
`define AIFQ_EVT_WMARK 1
`define AIFQ_EVT_OVRUN 0

// output format control fields
`define AIFQ_FMT_SELF_TEST 7
`define AIFQ_FMT_THREE_WIRE 6
`define AIFQ_FMT_INVERT 5
`define AIFQ_FMT_CONST_SCALE 3
`define AIFQ_FMT_LEFT_JUST 2
`define AIFQ_FMT_RANGE_HI 1
`define AIFQ_FMT_RANGE_LO 0

// queue control and status fields
`define AIFQ_QC_MODE_HI 7
`define AIFQ_QC_MODE_LO 6
`define AIFQ_QC_TRIG_SRC 5
`define AIFQ_QC_COUNT_HI 4
`define AIFQ_QC_COUNT_LO 0
`define AIFQ_QS_TRIGGERED 7

// queue modes
`define AIFQ_MODE_BYPASS 2'h0
`define AIFQ_MODE_FILL 2'h1
`define AIFQ_MODE_STREAM 2'h2
`define AIFQ_MODE_TRIGGER 2'h3

// queue depth
`define AIFQ_DEPTH 32
`define AIFQ_PTR_W 5

// span in raw steps of the narrowest range
`define AIFQ_SPAN_BASE 14'h0200

`endif

// *** core/aifq_fmt.v ***
// Purpose: formats one raw axis sample by range, resolution and justification
// Assumes: raw input is signed, 4 mg per step, spans the widest range in 13 bits
// Notes: purely combinational, one instance per axis
`timescale 1ns/1ps
`include "aifq_defs.vh"

module aifq_fmt #(
	parameter signed [13:0] ST_SHIFT = 14'sh0040
) (
	input wire signed [12:0] i_raw,
	input wire [1:0] i_range,
	input wire i_const_scale,
	input wire i_left_just,
	input wire i_self_test,
	output reg [15:0] o_word
);

	reg signed [13:0] biased;
	reg signed [13:0] lim;
	reg signed [13:0] clip;
	reg signed [13:0] val;
	reg [4:0] width;
	reg [15:0] ext;

	// stimulus, clipping, scaling and placement in one pass
	always @* begin
		biased = {i_raw[12], i_raw} + (i_self_test ? ST_SHIFT : 14'sh0000);
		lim = $signed(`AIFQ_SPAN_BASE << i_range);
		clip = biased;
		if (i_range != 2'h3) begin
			// narrow ranges saturate instead of wrapping
			if (biased >= lim)
				clip = lim - 14'sh0001;
			else if (biased < -lim)
				clip = -lim;
		end else begin
			// widest range keeps the 13-bit field as is
			clip = {biased[12], biased[12:0]};
		end
		// fixed 10-bit mode scales by range, constant scale keeps 4 mg steps
		if (i_const_scale) begin
			val = clip;
			width = 5'd10 + {3'd0, i_range};
		end else begin
			val = clip >>> i_range;
			width = 5'd10;
		end
		ext = {{2{val[13]}}, val};
		// left placement puts the top bit at bit 15, right keeps sign extension
		if (i_left_just)
			o_word = ext << (5'd16 - width);
		else
			o_word = ext;
	end

endmodule // aifq_fmt

// *** core/aifq_top.v ***
// Purpose: interrupt routing, event flags, sample formatting and 32-entry sample queue
// Assumes: byte register port and detector events run on i_core_clk
// Notes: detection, power control and serial protocol engines sit outside
`timescale 1ns/1ps
`include "aifq_defs.vh"

module aifq_top #(
	parameter DEPTH = `AIFQ_DEPTH,
	parameter PTR_W = `AIFQ_PTR_W
) (
	input wire i_core_clk,
	input wire i_srst,
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_rd,
	input wire i_reg_xfer_end,
	output reg [7:0] o_reg_rdata,
	input wire i_sample_valid,
	input wire [12:0] i_x_raw,
	input wire [12:0] i_y_raw,
	input wire [12:0] i_z_raw,
	input wire i_evt_single_tap,
	input wire i_evt_double_tap,
	input wire i_evt_activity,
	input wire i_evt_inactivity,
	input wire i_evt_free_fall,
	output reg o_irq_pin_a,
	output reg o_irq_pin_b,
	output wire o_spi_three_wire,
	output wire o_self_test
);

	localparam [6:0] FULL_COUNT = DEPTH;

	// software registers
	reg [7:0] int_enable;
	reg [7:0] interrupt_pin_select;
	reg [7:0] output_format_ctrl;
	reg [7:0] sample_queue_ctrl;

	// event state
	reg [6:2] evt_sticky;
	reg overrun;
	reg queue_triggered;
	reg trig_level_d;
	reg data_read_seen;

	// queue storage and the output stage
	reg [47:0] mem [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr;
	reg [PTR_W-1:0] rd_ptr;
	reg [6:0] count;
	reg [47:0] out_stage;
	reg out_valid;

	wire [15:0] fmt_x;
	wire [15:0] fmt_y;
	wire [15:0] fmt_z;
	wire [1:0] mode;
	wire [4:0] wm_level;
	wire [6:0] entries;
	wire [7:0] evt_flags;
	wire [7:0] routed;
	wire level_a;
	wire level_b;
	wire trig_level;
	wire trig_rise;
	wire wmark;
	wire pop;
	wire rd_flags;
	wire wr_qctrl;
	wire load_out;
	reg push;
	reg drop;
	reg lost;

	function is_data_addr;
		input [7:0] a;
		begin
			is_data_addr = (a >= `AIFQ_OFS_X_LOW) && (a <= `AIFQ_OFS_Z_HIGH);
		end
	endfunction

	// three axis formatters share one set of format controls
	aifq_fmt u_fmt_x (
		.i_raw(i_x_raw),
		.i_range(output_format_ctrl[`AIFQ_FMT_RANGE_HI:`AIFQ_FMT_RANGE_LO]),
		.i_const_scale(output_format_ctrl[`AIFQ_FMT_CONST_SCALE]),
		.i_left_just(output_format_ctrl[`AIFQ_FMT_LEFT_JUST]),
		.i_self_test(output_format_ctrl[`AIFQ_FMT_SELF_TEST]),
		.o_word(fmt_x)
	);
	aifq_fmt u_fmt_y (
		.i_raw(i_y_raw),
		.i_range(output_format_ctrl[`AIFQ_FMT_RANGE_HI:`AIFQ_FMT_RANGE_LO]),
		.i_const_scale(output_format_ctrl[`AIFQ_FMT_CONST_SCALE]),
		.i_left_just(output_format_ctrl[`AIFQ_FMT_LEFT_JUST]),
		.i_self_test(output_format_ctrl[`AIFQ_FMT_SELF_TEST]),
		.o_word(fmt_y)
	);
	aifq_fmt u_fmt_z (
		.i_raw(i_z_raw),
		.i_range(output_format_ctrl[`AIFQ_FMT_RANGE_HI:`AIFQ_FMT_RANGE_LO]),
		.i_const_scale(output_format_ctrl[`AIFQ_FMT_CONST_SCALE]),
		.i_left_just(output_format_ctrl[`AIFQ_FMT_LEFT_JUST]),
		.i_self_test(output_format_ctrl[`AIFQ_FMT_SELF_TEST]),
		.o_word(fmt_z)
	);

	// control bits that leave the block directly
	assign o_self_test = output_format_ctrl[`AIFQ_FMT_SELF_TEST];
	assign o_spi_three_wire = output_format_ctrl[`AIFQ_FMT_THREE_WIRE];

	assign mode = sample_queue_ctrl[`AIFQ_QC_MODE_HI:`AIFQ_QC_MODE_LO];
	assign wm_level = sample_queue_ctrl[`AIFQ_QC_COUNT_HI:`AIFQ_QC_COUNT_LO];
	assign entries = count + {6'd0, out_valid};

	// watermark is a level on the entry count in fill and stream modes, so it falls as reads drain the queue; a zero setting holds it set
	assign wmark = (wm_level == 5'd0) ||
		(((mode == `AIFQ_MODE_FILL) || (mode == `AIFQ_MODE_STREAM)) &&
		(entries >= {2'd0, wm_level}));

	// data-ready and watermark follow queue contents, not the enables
	assign evt_flags = {out_valid, evt_sticky, wmark, overrun};

	// enable gates only the pin path; routing splits by bit value
	assign routed = evt_flags & int_enable;
	assign level_a = |(routed & ~interrupt_pin_select);
	assign level_b = |(routed & interrupt_pin_select);

	// trigger follows the internal pin level before polarity is applied
	assign trig_level = sample_queue_ctrl[`AIFQ_QC_TRIG_SRC] ? level_b : level_a;
	assign trig_rise = trig_level && !trig_level_d;

	assign rd_flags = i_reg_rd && (i_reg_addr == `AIFQ_OFS_EVT_FLAGS);
	assign wr_qctrl = i_reg_wr && (i_reg_addr == `AIFQ_OFS_QUEUE_CTRL);

	// a level pops once per transfer, however many data bytes it read
	assign pop = i_reg_xfer_end && out_valid &&
		(data_read_seen || (i_reg_rd && is_data_addr(i_reg_addr)));

	// output stage refills from the queue head whenever it is empty
	assign load_out = !out_valid && (count != 7'd0) && (mode != `AIFQ_MODE_BYPASS);

	// admission decision per mode
	always @* begin
		push = 1'b0;
		drop = 1'b0;
		lost = 1'b0;
		if (i_sample_valid && (mode != `AIFQ_MODE_BYPASS)) begin
			case (mode)
				`AIFQ_MODE_FILL: begin
					push = (count < FULL_COUNT);
					lost = !push;
				end
				`AIFQ_MODE_STREAM: begin
					push = 1'b1;
					drop = (count == FULL_COUNT) && !load_out;
					lost = drop;
				end
				`AIFQ_MODE_TRIGGER: begin
					if (queue_triggered) begin
						push = (count < FULL_COUNT);
						lost = !push;
					end else if (count < {2'd0, wm_level}) begin
						push = 1'b1;
					end else if (count != 7'd0) begin
						push = 1'b1;
						drop = !load_out;
					end
				end
				default: begin
					push = 1'b0;
				end
			endcase
		end
	end

	// register writes
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			int_enable <= `AIFQ_RST_BYTE;
			interrupt_pin_select <= `AIFQ_RST_BYTE;
			output_format_ctrl <= `AIFQ_RST_BYTE;
			sample_queue_ctrl <= `AIFQ_RST_BYTE;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`AIFQ_OFS_INT_ENABLE: int_enable <= i_reg_wdata;
				`AIFQ_OFS_PIN_SELECT: interrupt_pin_select <= i_reg_wdata;
				`AIFQ_OFS_FORMAT: output_format_ctrl <= i_reg_wdata & 8'hEF;
				`AIFQ_OFS_QUEUE_CTRL: sample_queue_ctrl <= i_reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// register reads, registered one cycle after the strobe
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			o_reg_rdata <= `AIFQ_RST_BYTE;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`AIFQ_OFS_INT_ENABLE: o_reg_rdata <= int_enable;
				`AIFQ_OFS_PIN_SELECT: o_reg_rdata <= interrupt_pin_select;
				`AIFQ_OFS_EVT_FLAGS: o_reg_rdata <= evt_flags;
				`AIFQ_OFS_FORMAT: o_reg_rdata <= output_format_ctrl;
				`AIFQ_OFS_X_LOW: o_reg_rdata <= out_stage[7:0];
				`AIFQ_OFS_X_HIGH: o_reg_rdata <= out_stage[15:8];
				`AIFQ_OFS_Y_LOW: o_reg_rdata <= out_stage[23:16];
				`AIFQ_OFS_Y_HIGH: o_reg_rdata <= out_stage[31:24];
				`AIFQ_OFS_Z_LOW: o_reg_rdata <= out_stage[39:32];
				`AIFQ_OFS_Z_HIGH: o_reg_rdata <= out_stage[47:40];
				`AIFQ_OFS_QUEUE_CTRL: o_reg_rdata <= sample_queue_ctrl;
				`AIFQ_OFS_QUEUE_STATUS: o_reg_rdata <= {queue_triggered, 1'b0, entries[5:0]};
				default: o_reg_rdata <= `AIFQ_RST_BYTE;
			endcase
		end
	end

	// sticky detector flags: a new event beats the read that clears it
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			evt_sticky <= 5'h00;
		end else begin
			evt_sticky <= (rd_flags ? 5'h00 : evt_sticky) | {i_evt_single_tap,
				i_evt_double_tap, i_evt_activity, i_evt_inactivity, i_evt_free_fall};
		end
	end

	// overrun marks a lost sample and clears with the next data pop
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			overrun <= 1'b0;
		end else if (lost || (i_sample_valid && mode == `AIFQ_MODE_BYPASS && out_valid && !pop)) begin
			overrun <= 1'b1;
		end else if (pop) begin
			overrun <= 1'b0;
		end
	end

	// trigger capture; rewriting the queue control rearms it
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			trig_level_d <= 1'b0;
			queue_triggered <= 1'b0;
		end else begin
			trig_level_d <= trig_level;
			if (mode == `AIFQ_MODE_TRIGGER && trig_rise)
				queue_triggered <= 1'b1;
			else if (wr_qctrl)
				queue_triggered <= 1'b0;
		end
	end

	// remember a data byte read until the transfer ends
	always @(posedge i_core_clk) begin
		if (i_srst)
			data_read_seen <= 1'b0;
		else if (i_reg_xfer_end)
			data_read_seen <= 1'b0;
		else if (i_reg_rd && is_data_addr(i_reg_addr))
			data_read_seen <= 1'b1;
	end

	// queue pointers and occupancy; entering bypass flushes stale levels
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			wr_ptr <= {PTR_W{1'b0}};
			rd_ptr <= {PTR_W{1'b0}};
			count <= 7'd0;
		end else if (mode == `AIFQ_MODE_BYPASS) begin
			wr_ptr <= {PTR_W{1'b0}};
			rd_ptr <= {PTR_W{1'b0}};
			count <= 7'd0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (load_out || drop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + {6'd0, push} - {6'd0, (load_out || drop)};
		end
	end

	// entry storage, one whole three-axis set per level
	always @(posedge i_core_clk) begin
		if (push)
			mem[wr_ptr] <= {fmt_z, fmt_y, fmt_x};
	end

	// output stage: bypass takes every sample, queue modes refill from the head
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			out_stage <= 48'h0000_0000_0000;
			out_valid <= 1'b0;
		end else if (mode == `AIFQ_MODE_BYPASS && i_sample_valid) begin
			out_stage <= {fmt_z, fmt_y, fmt_x};
			out_valid <= 1'b1;
		end else if (load_out) begin
			out_stage <= mem[rd_ptr];
			out_valid <= 1'b1;
		end else if (pop) begin
			out_valid <= 1'b0;
		end
	end

	// pins registered after polarity so they never glitch on decode
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			o_irq_pin_a <= 1'b0;
			o_irq_pin_b <= 1'b0;
		end else begin
			o_irq_pin_a <= level_a ^ output_format_ctrl[`AIFQ_FMT_INVERT];
			o_irq_pin_b <= level_b ^ output_format_ctrl[`AIFQ_FMT_INVERT];
		end
	end

endmodule // aifq_top

// *** tb/aifq_monitor.sv ***
// Purpose: port checks of the readout back end
// Assumes: registered read data, pins settle one cycle after a change
// Notes: bound to aifq_top
`timescale 1ns/1ps
module aifq_monitor #(
	parameter DEPTH = 32
) (
	input wire i_core_clk,
	input wire i_srst,
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_rd,
	input wire [7:0] o_reg_rdata,
	input wire o_irq_pin_a,
	input wire o_irq_pin_b,
	input wire o_spi_three_wire,
	input wire o_self_test
);
	reg [7:0] en_q;
	reg [7:0] map_q;
	reg inv_q;
	reg [1:0] quiet;
	wire cfg_wr = i_reg_wr && i_reg_addr >= 8'h2E && i_reg_addr <= 8'h31;
	// shadow of enables, routing and polarity; quiet counts settled cycles
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			en_q <= 8'h00;
			map_q <= 8'h00;
			inv_q <= 1'b0;
			quiet <= 2'd0;
		end else begin
			if (i_reg_wr && i_reg_addr == 8'h2E) en_q <= i_reg_wdata;
			if (i_reg_wr && i_reg_addr == 8'h2F) map_q <= i_reg_wdata;
			if (i_reg_wr && i_reg_addr == 8'h31) inv_q <= i_reg_wdata[5];
			if (cfg_wr) quiet <= 2'd0;
			else if (quiet != 2'd3) quiet <= quiet + 2'd1;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	sequence s_wr(a);
		i_reg_wr && i_reg_addr == a;
	endsequence
	sequence s_rd(a);
		i_reg_rd && i_reg_addr == a;
	endsequence
	// write then read of the same place returns the writable bits
	property p_rb(a, m);
		s_wr(a) ##2 s_rd(a) |=> o_reg_rdata == ($past(i_reg_wdata, 3) & m);
	endproperty
	chk_wiring_follow: assert property (s_wr(8'h31) |=>
		o_spi_three_wire == $past(i_reg_wdata[6])) else $error("wiring select wrong");
	chk_selftest_follow: assert property (s_wr(8'h31) |=>
		o_self_test == $past(i_reg_wdata[7])) else $error("self-test wrong");
	chk_entries_bound: assert property (s_rd(8'h39) |=>
		o_reg_rdata[5:0] <= DEPTH + 1 && !o_reg_rdata[6]) else $error("entries bad");
	chk_pins_idle: assert property (en_q == 8'h00 && quiet >= 2'd2 |->
		o_irq_pin_a == inv_q && o_irq_pin_b == inv_q) else $error("pin active");
	chk_route_pin_a: assert property (map_q == 8'h00 && quiet >= 2'd2 |->
		o_irq_pin_b == inv_q) else $error("pin b driven");
	chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved");
	chk_fmt_readback: assert property (p_rb(8'h31, 8'hEF))
		else $error("format readback");
	chk_qctl_readback: assert property (p_rb(8'h38, 8'hFF))
		else $error("queue ctrl readback");
endmodule // aifq_monitor

bind aifq_top aifq_monitor #(
	.DEPTH(DEPTH)
) aifq_monitor_inst (
	.i_core_clk(i_core_clk),
	.i_srst(i_srst),
	.i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr),
	.i_reg_wdata(i_reg_wdata),
	.i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata),
	.o_irq_pin_a(o_irq_pin_a),
	.o_irq_pin_b(o_irq_pin_b),
	.o_spi_three_wire(o_spi_three_wire),
	.o_self_test(o_self_test)
);

// *** tb/aifq_host_model.sv ***
// Purpose: host side of the byte register port
// Assumes: strobes change at the falling edge
// Notes: idle address and data show inverted values, never stale ones
`timescale 1ns/1ps
module aifq_host_model (
	input wire i_core_clk,
	input wire [7:0] i_reg_rdata,
	output reg [7:0] o_addr,
	output reg o_wr,
	output reg [7:0] o_wdata,
	output reg o_rd,
	output reg o_xfer_end
);
	// quiet port at time zero
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
		o_xfer_end = 1'b0;
	end
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge i_core_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_core_clk);
		o_wr = 1'b0;
		o_wdata = ~d;
		o_addr = ~a;
	end
	endtask
	// read data stands from the cycle after the strobe
	task rd(input [7:0] a, output [7:0] d);
	begin
		@(negedge i_core_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_core_clk);
		d = i_reg_rdata;
		o_rd = 1'b0;
		o_addr = ~a;
	end
	endtask
	// all six bytes in one transfer so a level pops once
	task burst(output [47:0] w);
		integer k;
		reg [7:0] d;
	begin
		for (k = 0; k < 6; k = k + 1) begin
			rd(8'h32 + k[7:0], d);
			w[8*k +: 8] = d;
		end
		@(negedge i_core_clk);
		o_xfer_end = 1'b1;
		@(negedge i_core_clk);
		o_xfer_end = 1'b0;
	end
	endtask
endmodule // aifq_host_model

// *** tb/test_accel_irq_format_fifo.sv ***
// Purpose: register level test of the readout back end
// Assumes: host model drives the port at falling edges
// Notes: self-test shift taken as the formatter default of 64 steps
`timescale 1ns/1ps
module test_accel_irq_format_fifo;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg sv = 1'b0;
	reg [12:0] xr = 13'h0000;
	reg [12:0] yr = 13'h0000;
	reg [12:0] zr = 13'h0000;
	reg [4:0] evt = 5'h00;
	wire [7:0] addr;
	wire [7:0] wdat;
	wire [7:0] rdat;
	wire hwr;
	wire hrd;
	wire xe;
	wire pa;
	wire pb;
	wire tw;
	wire st;
	integer error_cnt = 0;
	integer checked = 0;
	integer i;
	reg [7:0] b;
	reg [47:0] w;
	// 100 MHz core clock
	always #5 clk = ~clk;
	aifq_top aifq_top_inst (
		.i_core_clk(clk),
		.i_srst(srst),
		.i_reg_addr(addr),
		.i_reg_wr(hwr),
		.i_reg_wdata(wdat),
		.i_reg_rd(hrd),
		.i_reg_xfer_end(xe),
		.o_reg_rdata(rdat),
		.i_sample_valid(sv),
		.i_x_raw(xr),
		.i_y_raw(yr),
		.i_z_raw(zr),
		.i_evt_single_tap(evt[4]),
		.i_evt_double_tap(evt[3]),
		.i_evt_activity(evt[2]),
		.i_evt_inactivity(evt[1]),
		.i_evt_free_fall(evt[0]),
		.o_irq_pin_a(pa),
		.o_irq_pin_b(pb),
		.o_spi_three_wire(tw),
		.o_self_test(st)
	);
	aifq_host_model aifq_host_model_inst (
		.i_core_clk(clk),
		.i_reg_rdata(rdat),
		.o_addr(addr),
		.o_wr(hwr),
		.o_wdata(wdat),
		.o_rd(hrd),
		.o_xfer_end(xe)
	);
	task close_out;
	begin
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task chk(input [15:0] g, input [15:0] e);
	begin
		checked = checked + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task idle(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task put(input [7:0] a, input [7:0] d);
		aifq_host_model_inst.wr(a, d);
	endtask
	task rr(input [7:0] a, input [7:0] m, input [7:0] e);
	begin
		aifq_host_model_inst.rd(a, b);
		chk({8'h00, b & m}, {8'h00, e});
	end
	endtask
	task smp(input [12:0] x);
	begin
		@(negedge clk);
		xr = x;
		sv = 1'b1;
		@(negedge clk);
		sv = 1'b0;
	end
	endtask
	task pulse(input integer k);
	begin
		@(negedge clk);
		evt = 5'h01 << k;
		@(negedge clk);
		evt = 5'h00;
	end
	endtask
	// one bypass sample under format f, X word compared
	task fcase(input [7:0] f, input [12:0] x, input [15:0] e);
	begin
		put(8'h31, f);
		smp(x);
		idle(3);
		aifq_host_model_inst.rd(8'h32, b);
		w[7:0] = b;
		aifq_host_model_inst.rd(8'h33, b);
		chk({b, w[7:0]}, e);
	end
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt = error_cnt + 1;
		close_out;
	end
	initial begin
		repeat (12) @(negedge clk);
		srst = 1'b0;
		rr(8'h2F, 8'hFF, 8'h00);
		rr(8'h38, 8'hFF, 8'h00);
		rr(8'h00, 8'hFF, 8'h00);
		put(8'h31, 8'hFF);
		rr(8'h31, 8'hFF, 8'hEF);
		chk({14'h0000, tw, st}, 16'h0003);
		fcase(8'h00, 13'h0064, 16'h0064);
		fcase(8'h00, 13'h07D0, 16'h01FF);
		fcase(8'h01, 13'h0258, 16'h012C);
		fcase(8'h03, 13'h07D0, 16'h00FA);
		fcase(8'h0B, 13'h07D0, 16'h07D0);
		fcase(8'h04, 13'h0064, 16'h1900);
		fcase(8'h08, 13'h1FFB, 16'hFFFB);
		fcase(8'h02, 13'h07D0, 16'h01F4);
		fcase(8'h00, 13'h1000, 16'hFE00);
		fcase(8'h0A, 13'h0BB8, 16'h07FF);
		fcase(8'h0F, 13'h0001, 16'h0008);
		fcase(8'h80, 13'h0064, 16'h00A4);
		chk({14'h0000, tw, st}, 16'h0001);
		put(8'h31, 8'h00);
		yr = 13'h0002;
		zr = 13'h1FFD;
		smp(13'h0001);
		idle(3);
		rr(8'h30, 8'h82, 8'h82);
		aifq_host_model_inst.burst(w);
		chk(w[47:32], 16'hFFFD);
		chk(w[31:16], 16'h0002);
		chk(w[15:0], 16'h0001);
		idle(3);
		rr(8'h30, 8'h83, 8'h02);
		// detectors run with enables off; a source read clears each flag
		for (i = 0; i < 5; i = i + 1) begin
			pulse(i);
			idle(2);
			chk({14'h0000, pa, pb}, 16'h0000);
			rr(8'h30, 8'h7C, 8'h04 << i);
			rr(8'h30, 8'h7C, 8'h00);
		end
		put(8'h2E, 8'h40);
		put(8'h2F, 8'h00);
		pulse(4);
		idle(2);
		chk({14'h0000, pa, pb}, 16'h0002);
		put(8'h2F, 8'hFF);
		idle(2);
		chk({14'h0000, pa, pb}, 16'h0001);
		put(8'h31, 8'h20);
		idle(2);
		chk({14'h0000, pa, pb}, 16'h0002);
		rr(8'h30, 8'h40, 8'h40);
		idle(2);
		chk({14'h0000, pa, pb}, 16'h0003);
		put(8'h31, 8'h00);
		put(8'h2E, 8'h00);
		put(8'h38, 8'h44);
		rr(8'h38, 8'hFF, 8'h44);
		for (i = 1; i <= 34; i = i + 1)
			smp(i[12:0]);
		idle(3);
		rr(8'h39, 8'hFF, 8'h21);
		rr(8'h30, 8'h83, 8'h83);
		aifq_host_model_inst.burst(w);
		chk(w[15:0], 16'h0001);
		idle(3);
		rr(8'h39, 8'hFF, 8'h20);
		put(8'h38, 8'h00);
		put(8'h38, 8'h84);
		for (i = 101; i <= 140; i = i + 1)
			smp(i[12:0]);
		idle(3);
		rr(8'h39, 8'hFF, 8'h21);
		aifq_host_model_inst.burst(w);
		idle(3);
		aifq_host_model_inst.burst(w);
		chk(w[15:0], 16'h006D);
		put(8'h38, 8'h00);
		put(8'h2E, 8'h04);
		put(8'h38, 8'hC2);
		for (i = 1; i <= 5; i = i + 1)
			smp(i[12:0]);
		idle(3);
		rr(8'h39, 8'hFF, 8'h03);
		pulse(0);
		idle(3);
		rr(8'h39, 8'h80, 8'h00);
		put(8'h2F, 8'h00);
		idle(3);
		rr(8'h39, 8'h80, 8'h80);
		smp(13'h0006);
		idle(3);
		rr(8'h39, 8'hFF, 8'h84);
		// rewrite rearms; pin b as source only fires once the flag is routed there
		put(8'h38, 8'hE2);
		idle(3);
		rr(8'h39, 8'h80, 8'h00);
		put(8'h2F, 8'hFF);
		idle(3);
		rr(8'h39, 8'h80, 8'h80);
		close_out;
	end
endmodule // test_accel_irq_format_fifo
